// File: include/e3m_pkg.sv
// constants, register map and types of the e3 receive sync and alarm monitor
package e3m_pkg;

	// ----------------------------------------
	// frame geometry
	// ----------------------------------------
	localparam logic [12:0] FRAME_LAST = 13'd4295;
	localparam logic [15:0] FA_WORD = 16'hf628;
	localparam logic [12:0] CNT_ZERO = 13'h0000;
	localparam logic [12:0] CNT_ONE = 13'h0001;

	// ----------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------
	localparam logic [7:0] IDX_IO_CONTROL = 8'h01;
	localparam logic [7:0] IDX_RX_STATUS = 8'h11;
	localparam logic [7:0] IDX_EVENT = 8'h14;
	localparam logic [7:0] IDX_ERR_HIGH = 8'h52;
	localparam logic [7:0] IDX_ERR_LOW = 8'h53;

	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int IO_REFRAME_BIT = 0;
	localparam logic [7:0] IO_CONTROL_RESET = 8'ha0;
	localparam logic [7:0] IO_CONTROL_WMASK = 8'hbe;
	localparam int ST_DWELL_SEL_BIT = 7;
	localparam int EV_OOF_BIT = 3;
	localparam int EV_LOF_BIT = 2;
	localparam int EV_LOS_BIT = 1;
	localparam int EV_AIS_BIT = 0;

	// ----------------------------------------
	// alarm thresholds
	// ----------------------------------------
	localparam logic [4:0] DWELL_LONG = 5'h18;
	localparam logic [4:0] DWELL_SHORT = 5'h08;
	localparam logic [2:0] OOF_BAD_FRAMES = 3'h4;
	localparam logic [5:0] LOS_ZERO_RUN = 6'h20;
	localparam logic [5:0] LOS_CLEAR_SPAN = 6'h20;
	localparam logic [5:0] LOS_BAD_RUN = 6'h04;
	localparam logic [3:0] AIS_MAX_ZEROS = 4'h7;
	localparam logic [15:0] ERR_MAX = 16'hffff;

	typedef enum logic [1:0] {FS_IN_FRAME, FS_OOF, FS_LOF} e3m_frame_state_type;

endpackage

// File: rtl/e3m_sync.sv
// two flip-flop synchroniser for the line-side inputs
`timescale 1ns/10ps
module e3m_sync
(
	input wire logic core_clk, // system clock
	input wire logic rst_n, // asynchronous reset, active low
	input wire logic [3:0] async_in, // inputs from the line side
	output logic [3:0] sync_out // synchronised copy
);
	logic [3:0] meta_q;
	logic [3:0] stable_q;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= 4'h0;
			stable_q <= 4'h0;
		end
		else
		begin
			meta_q <= async_in;
			stable_q <= meta_q;
		end
	end

	assign sync_out = stable_q;
endmodule

// File: rtl/e3m_monitor.sv
// e3 receive frame sync and alarm monitor with a classic wishbone register slave
//
// Operation
// RQ1: writing one to io_control bit 0 restarts the alignment word search
// RQ2: a reframe command drives both frame indication pins high
// RQ3: a reframe command sets the out-of-frame and loss-of-frame event flags
// RQ4: a reframe command sets status bits 6 and 5 at 0x11
// RQ5: 16-bit framing error count at 0x52/0x53, each byte clears on read
// RQ6: frame pins encode 00 in frame, 01 out of frame, 11 lost; never 10
// RQ7: 32 consecutive zero bits or the external input declare loss of signal
// RQ8: loss of signal drives its pin high and sets status bit 4
// RQ9: each loss of signal change sets event bit 1 at 0x14
// RQ10: loss of signal clears after 32 bits with no run of 4 zeros
// RQ11: clearing loss of signal sets the event, clears bit 4 and the pin
// RQ12: two consecutive frames with at most 7 zeros declare the all-ones alarm
// RQ13: each all-ones alarm change sets event bit 0 at 0x14
// RQ14: while all-ones alarm holds, its pin and status bit 3 are high
// RQ15: two consecutive frames with 8 or more zeros clear the all-ones alarm
// RQ16: clearing all-ones alarm drops its pin and status bit 3
// RQ17: status bit 7 picks out-of-frame dwell of 24 (0) or 8 (1) frames
// RQ18: four bad alignment frames in a row leave frame; every bad one counts
// RQ19: entering frame sets both events and drops both frame pins and bits
// RQ20: the framing error count saturates instead of wrapping
`timescale 1ns/10ps
module e3m_monitor
(
	input wire logic core_clk, // system clock, 20 MHz
	input wire logic rst_n, // asynchronous reset, active low
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write enable
	input wire logic [31:0] wb_adr_i, // wishbone byte address
	input wire logic [3:0] wb_sel_i, // wishbone byte lane select
	input wire logic [31:0] wb_dat_i, // wishbone write data
	output logic [31:0] wb_dat_o, // wishbone read data
	output logic wb_ack_o, // wishbone acknowledge
	input wire logic rx_line_clk, // receive line clock from the line interface
	input wire logic rx_positive_line_data, // positive rail line data
	input wire logic rx_negative_line_data, // negative rail line data
	input wire logic external_signal_loss_input, // loss of signal from the line interface
	output logic out_of_frame_indication, // out of frame pin
	output logic loss_of_frame_indication, // loss of frame pin
	output logic loss_of_signal_indication, // loss of signal pin
	output logic all_ones_alarm_indication // all-ones alarm pin
);
	import e3m_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		e3m_frame_state_type fr_state;
		logic [15:0] shift;
		logic [12:0] bit_cnt;
		logic [2:0] bad_frames;
		logic [4:0] dwell;
		logic [15:0] err_cnt;
		logic [5:0] zero_run;
		logic [5:0] good_span;
		logic los_line;
		logic loss_of_signal;
		logic [12:0] ais_bit_cnt;
		logic [3:0] ais_zeros;
		logic ais_prev_low;
		logic all_ones_alarm;
		logic [7:0] events;
		logic [7:0] io_ctrl;
		logic dwell_sel;
		logic clk_prev;
		logic reframe;
		logic ack;
		logic [7:0] dat;
	} e3m_state_type;

	localparam e3m_state_type STATE_RESET = '{
		fr_state: FS_LOF, shift: 16'h0000, bit_cnt: 13'h0000, bad_frames: 3'h0, dwell: 5'h00,
		err_cnt: 16'h0000, zero_run: 6'h00, good_span: 6'h00, los_line: 1'b0, loss_of_signal: 1'b0,
		ais_bit_cnt: 13'h0000, ais_zeros: 4'h0, ais_prev_low: 1'b0, all_ones_alarm: 1'b0, events: 8'h00,
		io_ctrl: IO_CONTROL_RESET, dwell_sel: 1'b0, clk_prev: 1'b0, reframe: 1'b0, ack: 1'b0,
		dat: 8'h00};

	e3m_state_type s_q;
	e3m_state_type s_d;
	logic [3:0] sync_in;
	logic [3:0] sync_q;
	logic line_clk_s;
	logic pos_s;
	logic neg_s;
	logic ext_los_s;

	// ----------------------------------------
	// line-side synchronisers
	// ----------------------------------------
	assign sync_in = {external_signal_loss_input, rx_negative_line_data, rx_positive_line_data, rx_line_clk};

	e3m_sync u_sync
	(
		.core_clk(core_clk),
		.rst_n(rst_n),
		.async_in(sync_in),
		.sync_out(sync_q)
	);

	assign line_clk_s = sync_q[0];
	assign pos_s = sync_q[1];
	assign neg_s = sync_q[2];
	assign ext_los_s = sync_q[3];

	// ----------------------------------------
	// next state
	// ----------------------------------------
	logic bus_req;
	logic rd;
	logic wr;
	logic [7:0] idx;
	logic line_edge;
	logic bit_in;
	logic [15:0] shift_n;
	logic [7:0] ev_set;
	logic err_inc;
	logic [4:0] dwell_limit;
	logic [5:0] zr_n;
	logic [3:0] az_n;
	logic frame_low;

	always_comb
	begin
		s_d = s_q;
		bus_req = wb_cyc_i & wb_stb_i & ~s_q.ack;
		rd = bus_req & ~wb_we_i;
		wr = bus_req & wb_we_i & wb_sel_i[0];
		idx = wb_adr_i[9:2];
		line_edge = line_clk_s & ~s_q.clk_prev;
		bit_in = pos_s | neg_s;
		shift_n = {s_q.shift[14:0], bit_in};
		ev_set = 8'h00;
		err_inc = 1'b0;
		dwell_limit = s_q.dwell_sel ? DWELL_SHORT : DWELL_LONG; // RQ17
		zr_n = s_q.zero_run;
		az_n = s_q.ais_zeros;
		frame_low = 1'b0;

		s_d.ack = bus_req;
		s_d.clk_prev = line_clk_s;
		s_d.reframe = wr && idx == IDX_IO_CONTROL && wb_dat_i[IO_REFRAME_BIT]; // RQ1

		// register writes
		if (wr && idx == IDX_IO_CONTROL)
			s_d.io_ctrl = wb_dat_i[7:0] & IO_CONTROL_WMASK;
		if (wr && idx == IDX_RX_STATUS)
			s_d.dwell_sel = wb_dat_i[ST_DWELL_SEL_BIT];

		// register reads, taken with the acknowledge
		if (rd)
		begin
			case (idx)
				IDX_IO_CONTROL: s_d.dat = s_q.io_ctrl;
				IDX_RX_STATUS: s_d.dat = {s_q.dwell_sel, loss_of_frame_indication, out_of_frame_indication,
					s_q.loss_of_signal, s_q.all_ones_alarm, 3'h0}; // RQ4 RQ8 RQ14
				IDX_EVENT: s_d.dat = s_q.events;
				IDX_ERR_HIGH: s_d.dat = s_q.err_cnt[15:8]; // RQ5
				IDX_ERR_LOW: s_d.dat = s_q.err_cnt[7:0]; // RQ5
				default: s_d.dat = 8'h00;
			endcase
		end

		if (line_edge)
		begin
			// frame search and maintenance
			s_d.shift = shift_n;
			case (s_q.fr_state)
				FS_IN_FRAME:
				begin
					if (s_q.bit_cnt == FRAME_LAST)
					begin
						s_d.bit_cnt = CNT_ZERO;
						if (shift_n != FA_WORD)
						begin
							err_inc = 1'b1; // RQ18
							s_d.bad_frames = s_q.bad_frames + 3'h1;
							if (s_q.bad_frames + 3'h1 == OOF_BAD_FRAMES) // RQ18
							begin
								s_d.fr_state = FS_OOF;
								s_d.bad_frames = 3'h0;
								s_d.dwell = 5'h00;
								ev_set[EV_OOF_BIT] = 1'b1;
							end
						end
						else
							s_d.bad_frames = 3'h0;
					end
					else
						s_d.bit_cnt = s_q.bit_cnt + CNT_ONE;
				end
				FS_OOF, FS_LOF:
				begin
					if (shift_n == FA_WORD)
					begin
						s_d.fr_state = FS_IN_FRAME; // RQ19
						s_d.bit_cnt = CNT_ZERO;
						s_d.bad_frames = 3'h0;
						ev_set[EV_OOF_BIT] = 1'b1; // RQ19
						ev_set[EV_LOF_BIT] = 1'b1; // RQ19
					end
					else if (s_q.bit_cnt == FRAME_LAST)
					begin
						s_d.bit_cnt = CNT_ZERO;
						if (s_q.fr_state == FS_OOF)
						begin
							s_d.dwell = s_q.dwell + 5'h01;
							if (s_q.dwell + 5'h01 >= dwell_limit) // RQ17
							begin
								s_d.fr_state = FS_LOF;
								ev_set[EV_LOF_BIT] = 1'b1;
							end
						end
					end
					else
						s_d.bit_cnt = s_q.bit_cnt + CNT_ONE;
				end
				default: s_d.fr_state = FS_LOF;
			endcase

			// loss of signal on the line data
			if (bit_in)
				zr_n = 6'h00;
			else if (s_q.zero_run != LOS_ZERO_RUN)
				zr_n = s_q.zero_run + 6'h01;
			s_d.zero_run = zr_n;
			if (zr_n >= LOS_BAD_RUN)
				s_d.good_span = 6'h00; // RQ10
			else if (s_q.good_span != LOS_CLEAR_SPAN)
				s_d.good_span = s_q.good_span + 6'h01;
			if (zr_n == LOS_ZERO_RUN)
				s_d.los_line = 1'b1; // RQ7
			else if (s_d.good_span == LOS_CLEAR_SPAN)
				s_d.los_line = 1'b0; // RQ10

			// all-ones alarm, zeros counted per free-running frame
			if (!bit_in && s_q.ais_zeros != AIS_MAX_ZEROS + 4'h1)
				az_n = s_q.ais_zeros + 4'h1;
			if (s_q.ais_bit_cnt == FRAME_LAST)
			begin
				s_d.ais_bit_cnt = CNT_ZERO;
				s_d.ais_zeros = 4'h0;
				frame_low = az_n <= AIS_MAX_ZEROS;
				if (frame_low && s_q.ais_prev_low)
					s_d.all_ones_alarm = 1'b1; // RQ12
				else if (!frame_low && !s_q.ais_prev_low)
					s_d.all_ones_alarm = 1'b0; // RQ15 RQ16
				s_d.ais_prev_low = frame_low;
			end
			else
			begin
				s_d.ais_bit_cnt = s_q.ais_bit_cnt + CNT_ONE;
				s_d.ais_zeros = az_n;
			end
		end

		// software reframe overrides the framer
		if (s_q.reframe)
		begin
			s_d.fr_state = FS_LOF; // RQ1 RQ2 RQ4
			s_d.bit_cnt = CNT_ZERO;
			s_d.bad_frames = 3'h0;
			s_d.dwell = 5'h00;
			ev_set[EV_OOF_BIT] = 1'b1; // RQ3
			ev_set[EV_LOF_BIT] = 1'b1; // RQ3
		end

		s_d.loss_of_signal = s_d.los_line | ext_los_s; // RQ7
		if (s_d.loss_of_signal != s_q.loss_of_signal)
			ev_set[EV_LOS_BIT] = 1'b1; // RQ9 RQ11
		if (s_d.all_ones_alarm != s_q.all_ones_alarm)
			ev_set[EV_AIS_BIT] = 1'b1; // RQ13

		// event flags clear on read; a new event wins over the clear
		s_d.events = ((rd && idx == IDX_EVENT) ? 8'h00 : s_q.events) | ev_set;

		// error count: each byte clears when read, saturating increment
		if (rd && idx == IDX_ERR_HIGH)
			s_d.err_cnt[15:8] = 8'h00; // RQ5
		if (rd && idx == IDX_ERR_LOW)
			s_d.err_cnt[7:0] = 8'h00; // RQ5
		if (err_inc && s_d.err_cnt != ERR_MAX)
			s_d.err_cnt = s_d.err_cnt + 16'h0001; // RQ18 RQ20
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			s_q <= STATE_RESET;
		else
			s_q <= s_d;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign out_of_frame_indication = s_q.fr_state != FS_IN_FRAME; // RQ6
	assign loss_of_frame_indication = s_q.fr_state == FS_LOF; // RQ6
	assign loss_of_signal_indication = s_q.loss_of_signal; // RQ8 RQ11
	assign all_ones_alarm_indication = s_q.all_ones_alarm; // RQ14 RQ16
	assign wb_ack_o = s_q.ack;
	assign wb_dat_o = {24'h000000, s_q.dat};

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence seq_lost_pins;
		out_of_frame_indication && loss_of_frame_indication;
	endsequence

	sequence seq_both_events;
		s_q.events[EV_OOF_BIT] && s_q.events[EV_LOF_BIT];
	endsequence

	a_pin_code_legal: assert property (!(loss_of_frame_indication && !out_of_frame_indication)) // RQ6
		else $error("frame pins show the invalid code");
	a_reframe_pins: assert property (s_q.reframe |=> seq_lost_pins) // RQ2
		else $error("reframe did not raise both frame pins");
	a_reframe_events: assert property (s_q.reframe |=> seq_both_events) // RQ3
		else $error("reframe did not set both frame events");
	a_reframe_cmd: assert property (wr && idx == IDX_IO_CONTROL && wb_dat_i[IO_REFRAME_BIT] |=> ##1 seq_lost_pins) // RQ1
		else $error("reframe write did not restart the search");
	a_inframe_events: assert property ($rose(s_q.fr_state == FS_IN_FRAME) |-> seq_both_events) // RQ19
		else $error("entering frame did not set both events");
	a_ext_los: assert property (ext_los_s |=> loss_of_signal_indication) // RQ7
		else $error("external loss input did not declare loss of signal");
	a_los_event: assert property ($changed(loss_of_signal_indication) |-> s_q.events[EV_LOS_BIT]) // RQ9
		else $error("loss of signal change without event");
	a_ais_event: assert property ($changed(all_ones_alarm_indication) |-> s_q.events[EV_AIS_BIT]) // RQ13
		else $error("all-ones alarm change without event");
	a_dwell_bound: assert property (s_q.fr_state == FS_OOF |-> s_q.dwell < dwell_limit) // RQ17
		else $error("out of frame dwell passed its limit");
	a_err_saturate: assert property (s_q.err_cnt == ERR_MAX && !rd |=> s_q.err_cnt == ERR_MAX) // RQ20
		else $error("error count wrapped");
	a_err_count: assert property (err_inc && !rd && s_q.err_cnt != ERR_MAX |=> s_q.err_cnt == $past(s_q.err_cnt) + 16'h0001) // RQ18
		else $error("bad alignment not counted");
endmodule

// File: testbench/e3m_liu_model.sv
// line interface model: free-running line clock and bipolar receive data from a bit queue
`timescale 1ns/10ps
module e3m_liu_model
(
	input wire logic ext_req, // loss request from the bench
	output logic rx_line_clk, // receive line clock, 400 ns
	output logic rx_pos, // positive rail
	output logic rx_neg, // negative rail
	output logic ext_loss // external loss of signal
);
	bit bits_q[$];
	logic mark_q;
	logic b;

	// ----------------------------------------
	// line clock and data
	// ----------------------------------------
	initial
	begin
		rx_line_clk = 1'b0;
		rx_pos = 1'b0;
		rx_neg = 1'b0;
		mark_q = 1'b0;
	end
	always #200 rx_line_clk = ~rx_line_clk;
	assign ext_loss = ext_req;

	// data moves on the falling edge so it is stable at the sampling edge; ones alternate rails
	always @(negedge rx_line_clk)
	begin
		b = (bits_q.size() > 0) ? bits_q.pop_front() : 1'b1;
		rx_pos <= b & ~mark_q;
		rx_neg <= b & mark_q;
		if (b)
			mark_q <= ~mark_q;
	end

	// ----------------------------------------
	// queue tasks
	// ----------------------------------------
	task send_run(input bit v, input int n);
		for (int i = 0; i < n; i++)
			bits_q.push_back(v);
	endtask
	task send_word(input logic [15:0] w);
		for (int i = 15; i >= 0; i--)
			bits_q.push_back(w[i]);
	endtask
endmodule

// File: testbench/test_e3_rx_sync_alarm_monitor.sv
// self-checking bench of the e3 receive sync and alarm monitor
`timescale 1ns/10ps
module test_e3_rx_sync_alarm_monitor;
	import e3m_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [31:0] wb_adr_i = 32'h0;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic rx_line_clk, rx_pos, rx_neg, ext_loss;
	logic ext_req = 1'b0;
	logic oof_pin, lof_pin, los_pin, ais_pin;
	int mismatches = 0;
	int checked = 0;
	int cycles = 0;
	int edges = 0;
	localparam int FRAME_BITS = int'(FRAME_LAST) + 1;
	integer seed = 32'h0876842b;
	logic [31:0] rv;
	logic [31:0] exp_io;
	int exp_st;
	logic [31:0] rd;

	always #25 core_clk = ~core_clk;

	e3m_liu_model u_e3m_liu_model (.ext_req(ext_req), .rx_line_clk(rx_line_clk), .rx_pos(rx_pos),
		.rx_neg(rx_neg), .ext_loss(ext_loss));
	e3m_monitor u_e3m_monitor (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .rx_line_clk(rx_line_clk), .rx_positive_line_data(rx_pos),
		.rx_negative_line_data(rx_neg), .external_signal_loss_input(ext_loss),
		.out_of_frame_indication(oof_pin), .loss_of_frame_indication(lof_pin),
		.loss_of_signal_indication(los_pin), .all_ones_alarm_indication(ais_pin));

	// ----------------------------------------
	// checking and bus tasks
	// ----------------------------------------
	task check(input string name, input logic [31:0] seen, input logic [31:0] expv);
		checked++;
		if (seen !== expv)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, expv, seen);
		end
	endtask
	task wb_cycle(input logic we, input logic [7:0] idx, input logic [31:0] wd, input logic [3:0] sel);
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {22'h0, idx, 2'b00};
		wb_sel_i <= sel;
		wb_dat_i <= wd;
		do
			@(posedge core_clk);
		while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task rd_chk(input string name, input logic [7:0] idx, input int expv);
		wb_cycle(1'b0, idx, 32'h0, 4'hf);
		check(name, rd, expv[31:0]);
	endtask
	task pins_chk(input logic [3:0] expv);
		check("pins", {28'h0, lof_pin, oof_pin, los_pin, ais_pin}, {28'h0, expv});
	endtask
	task line_wait();
		while (u_e3m_liu_model.bits_q.size() != 0)
			@(posedge core_clk);
		repeat (12) @(posedge core_clk);
	endtask
	task end_test(input string name);
		$display("test %s done", name);
	endtask
	task print_verdict();
		$display("comparisons %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 80000)
		begin
			mismatches++;
			print_verdict();
		end
	end

	// line edges since reset, kept in step with the free-running all-ones window
	always @(posedge rx_line_clk)
	begin
		if (rst_n)
			edges++;
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		exp_st = 32'h60;
		pins_chk(4'b1100);
		rd_chk("status", IDX_RX_STATUS, exp_st);
		rd_chk("io_control", IDX_IO_CONTROL, IO_CONTROL_RESET);
		rd_chk("events", IDX_EVENT, 0);
		rd_chk("err_high", IDX_ERR_HIGH, 0);
		rd_chk("err_low", IDX_ERR_LOW, 0);
		rd_chk("unmapped", 8'h3f, 0);
		rv = $random(seed);
		exp_io = rv & {24'h0, IO_CONTROL_WMASK};
		wb_cycle(1'b1, IDX_IO_CONTROL, rv, 4'h1);
		rd_chk("events", IDX_EVENT, rv[0] ? 32'h0c : 32'h0);
		rd_chk("io_control", IDX_IO_CONTROL, exp_io);
		wb_cycle(1'b1, IDX_RX_STATUS, 32'h80, 4'h0);
		rd_chk("status", IDX_RX_STATUS, exp_st);
		wb_cycle(1'b1, IDX_RX_STATUS, 32'h80, 4'h1);
		rd_chk("status", IDX_RX_STATUS, exp_st | 32'h80);
		wb_cycle(1'b1, IDX_RX_STATUS, 32'h00, 4'h1);
		end_test("registers");

		@(posedge core_clk);
		ext_req <= 1'b1;
		repeat (8) @(posedge core_clk);
		pins_chk(4'b1110);
		rd_chk("status", IDX_RX_STATUS, exp_st | 32'h10);
		rd_chk("events", IDX_EVENT, 32'h02);
		ext_req <= 1'b0;
		repeat (8) @(posedge core_clk);
		pins_chk(4'b1100);
		rd_chk("status", IDX_RX_STATUS, exp_st);
		rd_chk("events", IDX_EVENT, 32'h02);
		end_test("external_loss");

		// alignment word straddles the first window end, so both windows hold at most 7 zeros
		while (edges < FRAME_BITS - 8)
			@(posedge core_clk);
		u_e3m_liu_model.send_word(FA_WORD);
		line_wait();
		exp_st = 0;
		pins_chk(4'b0000);
		rd_chk("status", IDX_RX_STATUS, exp_st);
		rd_chk("events", IDX_EVENT, 32'h0c);
		// past the second window end and the first in-frame alignment check
		while (edges < 2 * FRAME_BITS + 8)
			@(posedge core_clk);
		repeat (12) @(posedge core_clk);
		exp_st = 32'h08;
		pins_chk(4'b0001);
		rd_chk("status", IDX_RX_STATUS, exp_st);
		rd_chk("events", IDX_EVENT, 32'h01);
		rd_chk("err_high", IDX_ERR_HIGH, 0);
		rd_chk("err_low", IDX_ERR_LOW, 1);
		rd_chk("err_low", IDX_ERR_LOW, 0);
		end_test("framing_and_all_ones");

		u_e3m_liu_model.send_run(1'b0, 40);
		line_wait();
		pins_chk(4'b0011);
		rd_chk("status", IDX_RX_STATUS, exp_st | 32'h10);
		rd_chk("events", IDX_EVENT, 32'h02);
		rd_chk("events", IDX_EVENT, 0);
		u_e3m_liu_model.send_run(1'b1, 40);
		line_wait();
		pins_chk(4'b0001);
		rd_chk("status", IDX_RX_STATUS, exp_st);
		rd_chk("events", IDX_EVENT, 32'h02);
		end_test("loss_of_signal");

		wb_cycle(1'b1, IDX_IO_CONTROL, exp_io | 32'h1, 4'h1);
		repeat (4) @(posedge core_clk);
		exp_st = 32'h68;
		pins_chk(4'b1101);
		rd_chk("status", IDX_RX_STATUS, exp_st);
		rd_chk("events", IDX_EVENT, 32'h0c);
		rd_chk("io_control", IDX_IO_CONTROL, exp_io);
		end_test("reframe");
		print_verdict();
	end
endmodule
